// ### src/bis_top.sv
// boost interrupt flags, charger timeout flags and live input sense register
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bis_consts.svh"

// Overview of operation
// - heavy vbus overload latches boost bit 3
// - heavy overload conditional clear, startup/off/reset/charge clear
// - boost capacitor overload latches boost bit 2
// - capacitor overload clears on any boost register read made once its cause is gone
// - vbus overvoltage latches bit 1, conditional clear
// - battery out of range latches bit 0
// - boost bits 7..4 reserved, read zero
// - sense register at 07 mirrors live comparators
// - sense bit 7 input lockout, bit 6 zero
// - sense bit 5 input above usb range
// - sense bit 4 input below usb range
// - sense bit 3 input present
// - sense bit 2 charger headroom present
// - sense bit 1 otg vbus undervoltage
// - charger register bit 0 summarises pending flags
// - charger timeout flags at bits 3,2,1
module bis_top
	import bis_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// boost side conditions, levels
	input wire logic vbus_heavy_overload_in,
	input wire logic boost_cap_overload_in,
	input wire logic vbus_overvoltage_in,
	input wire logic battery_range_fault_in,
	// charger timer events, one-cycle pulses
	input wire logic watchdog_expired_in,
	input wire logic usb_timer_expired_in,
	input wire logic charge_timer_expired_in,
	// live comparator outputs
	input wire logic input_lockout_live_in,
	input wire logic input_above_usb_range_in,
	input wire logic input_below_usb_range_in,
	input wire logic input_present_live_in,
	input wire logic input_headroom_live_in,
	input wire logic otg_undervoltage_live_in,
	// device states and mode changes that clear flags
	input wire logic off_state_in,
	input wire logic boost_startup_in,
	input wire logic charge_mode_entry_in,
	input wire logic host_supply_mode_entry_in,
	// self-clearing resets issued through the control register
	output logic soft_reset_out,
	output logic trim_reload_reset_out
);

	// decode shared by the read and the write paths
	function automatic bis_sel_t bis_decode(input logic [7:0] addr);
		bis_sel_t sel;
		sel = BIS_SEL_NONE;
		unique case (addr)
			`BIS_OFS_CHG_IRQ: sel = BIS_SEL_CHG;
			`BIS_OFS_BST_IRQ: sel = BIS_SEL_BST;
			`BIS_OFS_SNS: sel = BIS_SEL_SNS;
			`BIS_OFS_CTRL: sel = BIS_SEL_CTRL;
			`BIS_OFS_LIVE: sel = BIS_SEL_LIVE;
			default: sel = BIS_SEL_NONE;
		endcase
		return sel;
	endfunction

	bis_sel_t rd_sel;
	bis_sel_t wr_sel;
	logic rd_chg;
	logic rd_bst;

	// strobes qualified by the decoded register
	assign rd_sel = reg_rd_in ? bis_decode(reg_addr_in) : BIS_SEL_NONE;
	assign wr_sel = reg_wr_in ? bis_decode(reg_addr_in) : BIS_SEL_NONE;
	assign rd_chg = (rd_sel == BIS_SEL_CHG);
	assign rd_bst = (rd_sel == BIS_SEL_BST);

	// control register: self-clearing reset pulses
	logic soft_rst_r;
	logic soft_rst_nxt;
	logic trim_rst_r;
	logic trim_rst_nxt;

	// a write with the bit set gives one pulse in the following cycle
	always_comb begin
		soft_rst_nxt = 1'b0;
		trim_rst_nxt = 1'b0;
		if (wr_sel == BIS_SEL_CTRL) begin
			soft_rst_nxt = reg_wdata_in[`BIS_CTRL_SOFT_RST_BIT];
			trim_rst_nxt = reg_wdata_in[`BIS_CTRL_TRIM_RST_BIT];
		end
	end

	// pulse registers
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			soft_rst_r <= 1'b0;
			trim_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= soft_rst_nxt;
			trim_rst_r <= trim_rst_nxt;
		end
	end

	assign soft_reset_out = soft_rst_r;
	assign trim_reload_reset_out = trim_rst_r;

	// clear sources; power-on reset is the async reset of each flag
	logic clr_heavy;
	logic clr_boost;
	logic clr_chg;

	assign clr_heavy = off_state_in || boost_startup_in || soft_rst_r || charge_mode_entry_in;
	assign clr_boost = off_state_in || soft_rst_r || charge_mode_entry_in;
	// charger timeouts are also cleared by trim reload and host supply entry
	assign clr_chg = off_state_in || soft_rst_r || trim_rst_r || host_supply_mode_entry_in;

	// boost flag wiring, indexed by bit position
	logic [3:0] bst_set;
	logic [3:0] bst_clr;
	logic [3:0] bst_flag;

	assign bst_set[`BIS_BST_HEAVY_BIT] = vbus_heavy_overload_in;
	assign bst_set[`BIS_BST_CAP_BIT] = boost_cap_overload_in;
	assign bst_set[`BIS_BST_OV_BIT] = vbus_overvoltage_in;
	assign bst_set[`BIS_BST_BAT_BIT] = battery_range_fault_in;

	assign bst_clr[`BIS_BST_HEAVY_BIT] = clr_heavy;
	assign bst_clr[`BIS_BST_CAP_BIT] = clr_boost;
	assign bst_clr[`BIS_BST_OV_BIT] = clr_boost;
	assign bst_clr[`BIS_BST_BAT_BIT] = clr_boost;

	// only the capacitor overload is plain read-clear; its read-clear loses to a cause still high
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_bst
			bis_flag #(
				.CLR_MODE((gb == `BIS_BST_CAP_BIT) ? BIS_RC_PLAIN : BIS_RC_COND)
			) u_flag (
				.core_clk_in(core_clk_in),
				.rst_n_in(rst_n_in),
				.set_in(bst_set[gb]),
				.cond_in(bst_set[gb]),
				.rd_clr_in(rd_bst),
				.src_clr_in(bst_clr[gb]),
				.flag_out(bst_flag[gb])
			);
		end
	endgenerate

	// charger timeout flags, bits 3..1; bit 0 position is the summary
	logic [3:1] chg_set;
	logic [3:1] chg_flag;

	assign chg_set[`BIS_CHG_WDT_BIT] = watchdog_expired_in;
	assign chg_set[`BIS_CHG_USB_BIT] = usb_timer_expired_in;
	assign chg_set[`BIS_CHG_TMR_BIT] = charge_timer_expired_in;

	// timeout pulses leave no standing cause, so plain read-clear
	genvar gc;
	generate
		for (gc = 1; gc < 4; gc++) begin : g_chg
			bis_flag #(
				.CLR_MODE(BIS_RC_PLAIN)
			) u_flag (
				.core_clk_in(core_clk_in),
				.rst_n_in(rst_n_in),
				.set_in(chg_set[gc]),
				.cond_in(1'b0),
				.rd_clr_in(rd_chg),
				.src_clr_in(clr_chg),
				.flag_out(chg_flag[gc])
			);
		end
	endgenerate

	// register images as the host sees them
	bis_byte_t chg_img;
	bis_byte_t bst_img;
	bis_byte_t sns_img;
	bis_byte_t live_img;

	always_comb begin
		chg_img = `BIS_BYTE_ZERO;
		chg_img[3:1] = chg_flag;
		chg_img[`BIS_CHG_SUM_BIT] = |chg_flag;
	end

	always_comb begin
		bst_img = {`BIS_NIB_ZERO, bst_flag};
	end

	// live comparators, no storage so no reset touches them
	always_comb begin
		sns_img = `BIS_BYTE_ZERO;
		sns_img[`BIS_SNS_LOCKOUT_BIT] = input_lockout_live_in;
		sns_img[`BIS_SNS_ABOVE_BIT] = input_above_usb_range_in;
		sns_img[`BIS_SNS_BELOW_BIT] = input_below_usb_range_in;
		sns_img[`BIS_SNS_PRESENT_BIT] = input_present_live_in;
		sns_img[`BIS_SNS_HEADROOM_BIT] = input_headroom_live_in;
		sns_img[`BIS_SNS_OTG_UV_BIT] = otg_undervoltage_live_in;
	end

	// raw boost causes, handy when a conditional flag refuses to clear
	always_comb begin
		live_img = {`BIS_NIB_ZERO, bst_set};
	end

	// read data: sampled at the read edge, before that edge's clear lands
	bis_byte_t rdata_r;
	bis_byte_t rdata_nxt;

	// every read answers, unmapped and control read zero
	always_comb begin
		rdata_nxt = `BIS_BYTE_ZERO;
		unique case (rd_sel)
			BIS_SEL_CHG: rdata_nxt = chg_img;
			BIS_SEL_BST: rdata_nxt = bst_img;
			BIS_SEL_SNS: rdata_nxt = sns_img;
			BIS_SEL_LIVE: rdata_nxt = live_img;
			BIS_SEL_CTRL: rdata_nxt = `BIS_BYTE_ZERO;
			BIS_SEL_NONE: rdata_nxt = `BIS_BYTE_ZERO;
		endcase
	end

	// data stand for exactly the cycle after the read strobe
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_r <= `BIS_BYTE_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_out = rdata_r;

endmodule
`default_nettype wire

// ### src/bis_consts.svh
// offsets, field positions, reset values and timing counts of the boost irq and sense block
`ifndef BIS_CONSTS_SVH
`define BIS_CONSTS_SVH

// register offsets (byte addresses on the plain register port)
`define BIS_OFS_CHG_IRQ 8'h05
`define BIS_OFS_BST_IRQ 8'h06
`define BIS_OFS_SNS 8'h07
`define BIS_OFS_CTRL 8'h08
`define BIS_OFS_LIVE 8'h09

// charger irq register fields
`define BIS_CHG_WDT_BIT 3
`define BIS_CHG_USB_BIT 2
`define BIS_CHG_TMR_BIT 1
`define BIS_CHG_SUM_BIT 0

// boost irq register fields
`define BIS_BST_HEAVY_BIT 3
`define BIS_BST_CAP_BIT 2
`define BIS_BST_OV_BIT 1
`define BIS_BST_BAT_BIT 0

// input sense register fields
`define BIS_SNS_LOCKOUT_BIT 7
`define BIS_SNS_ABOVE_BIT 5
`define BIS_SNS_BELOW_BIT 4
`define BIS_SNS_PRESENT_BIT 3
`define BIS_SNS_HEADROOM_BIT 2
`define BIS_SNS_OTG_UV_BIT 1

// control register fields, both self clearing
`define BIS_CTRL_SOFT_RST_BIT 0
`define BIS_CTRL_TRIM_RST_BIT 1

// reset and idle values
`define BIS_FLAG_RESET 1'b0
`define BIS_BYTE_ZERO 8'h00
`define BIS_NIB_ZERO 4'h0

// cycles from read strobe to read data
`define BIS_READ_LATENCY 1

`endif

// ### src/bis_pkg.sv
// types shared by the boost irq and sense block
package bis_pkg;

	// how a latched flag reacts to a read of its register
	typedef enum logic {
		BIS_RC_PLAIN = 1'b0,
		BIS_RC_COND = 1'b1
	} bis_clr_mode_t;

	// register selected by an address
	typedef enum logic [2:0] {
		BIS_SEL_NONE = 3'h0,
		BIS_SEL_CHG = 3'h1,
		BIS_SEL_BST = 3'h3,
		BIS_SEL_SNS = 3'h2,
		BIS_SEL_CTRL = 3'h6,
		BIS_SEL_LIVE = 3'h7
	} bis_sel_t;

	typedef logic [7:0] bis_byte_t;

endpackage

// ### src/bis_flag.sv
// one latched interrupt flag with read-clear and clear-source handling
`timescale 1ns/1ps
`default_nettype none
`include "bis_consts.svh"

module bis_flag
	import bis_pkg::*;
#(
	parameter bis_clr_mode_t CLR_MODE = BIS_RC_PLAIN
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic set_in,
	input wire logic cond_in,
	input wire logic rd_clr_in,
	input wire logic src_clr_in,
	output logic flag_out
);

	logic flag_r;
	logic flag_nxt;
	logic rd_kill;

	// conditional mode keeps the flag while its cause is still present
	assign rd_kill = rd_clr_in && ((CLR_MODE == BIS_RC_PLAIN) || !cond_in);

	// clears first, set last so a same-cycle event is never lost
	always_comb begin
		flag_nxt = flag_r;
		if (src_clr_in) begin
			flag_nxt = 1'b0;
		end
		if (rd_kill) begin
			flag_nxt = 1'b0;
		end
		if (set_in) begin
			flag_nxt = 1'b1;
		end
	end

	// flag storage
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_r <= `BIS_FLAG_RESET;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign flag_out = flag_r;

endmodule
`default_nettype wire

// ### bench/bis_chk.sv
// assertion checker for the boost irq and sense register block
`timescale 1ns/1ps
`default_nettype none
module bis_chk (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic vbus_heavy_overload_in,
	input wire logic boost_cap_overload_in,
	input wire logic vbus_overvoltage_in,
	input wire logic battery_range_fault_in,
	input wire logic off_state_in,
	input wire logic charge_mode_entry_in,
	input wire logic soft_reset_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// read strobes of the boost and charger registers and any boost cause
	wire rd_b = reg_rd_in && reg_addr_in == 8'h06;
	wire rd_c = reg_rd_in && reg_addr_in == 8'h05;
	wire hv = vbus_heavy_overload_in;
	wire cap = boost_cap_overload_in;
	wire ov = vbus_overvoltage_in;
	wire any_c = hv | cap | ov | battery_range_fault_in;
	// write of the soft reset bit; back to back writes must give back to back pulses
	wire wr_soft = reg_wr_in && reg_addr_in == 8'h08 && reg_wdata_in[0];
	idle_zero_a:
	assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("stray read data");
	bst_rsv_a:
	assert property ($past(rd_b) |-> reg_rdata_out[7:4] == 4'h0) else $error("reserved bits set");
	heavy_set_a:
	assert property ($past(hv, 2) && $past(rd_b) |-> reg_rdata_out[3]) else $error("heavy flag lost");
	cap_clr_a:
	assert property (rd_b && !cap ##1 !cap ##1 rd_b |=> !reg_rdata_out[2])
		else $error("cap flag kept");
	keep_cond_a:
	assert property (rd_b && ov ##1 ov ##1 rd_b |=> reg_rdata_out[1]) else $error("ov flag dropped");
	src_clr_a:
	assert property ((off_state_in || charge_mode_entry_in) && !any_c ##1 !any_c ##1 rd_b
		|=> reg_rdata_out[3:0] == 4'h0) else $error("flags survive clear");
	soft_pls_a:
	assert property (soft_reset_out == $past(wr_soft)) else $error("soft reset pulse wrong");
	chg_sum_a:
	assert property ($past(rd_c) |-> reg_rdata_out[0] == |reg_rdata_out[3:1])
		else $error("summary bit wrong");
endmodule
bind bis_top bis_chk u_chk (
	.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.vbus_heavy_overload_in(vbus_heavy_overload_in),
	.boost_cap_overload_in(boost_cap_overload_in),
	.vbus_overvoltage_in(vbus_overvoltage_in),
	.battery_range_fault_in(battery_range_fault_in),
	.off_state_in(off_state_in),
	.charge_mode_entry_in(charge_mode_entry_in),
	.soft_reset_out(soft_reset_out)
);
`default_nettype wire

// ### bench/bis_host.sv
// host model driving the plain register port
`timescale 1ns/1ps
`default_nettype none
module bis_host (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	// bus idle from time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// one-cycle write strobe beside address and data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
	endtask
	// data stands one cycle only, so it is taken just past the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// ### bench/test_bis_top.sv
// self-checking bench for the boost irq and sense block
`timescale 1ns/1ps
`default_nettype none
module test_bis_top;
	logic clk = 1'b0;
	logic rst_n;
	logic [3:0] c;
	logic [2:0] t;
	logic [5:0] l;
	logic [3:0] s;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd;
	logic trim;
	int err_count = 0;
	int comparisons = 0;
	// core clock
	always #5 clk = ~clk;
	bis_host i_host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));
	bis_top i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.vbus_heavy_overload_in(c[3]), .boost_cap_overload_in(c[2]),
		.vbus_overvoltage_in(c[1]), .battery_range_fault_in(c[0]),
		.watchdog_expired_in(t[2]), .usb_timer_expired_in(t[1]),
		.charge_timer_expired_in(t[0]), .input_lockout_live_in(l[5]),
		.input_above_usb_range_in(l[4]), .input_below_usb_range_in(l[3]),
		.input_present_live_in(l[2]), .input_headroom_live_in(l[1]),
		.otg_undervoltage_live_in(l[0]), .off_state_in(s[3]), .boost_startup_in(s[2]),
		.charge_mode_entry_in(s[1]), .host_supply_mode_entry_in(s[0]),
		.soft_reset_out(), .trim_reload_reset_out(trim));
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic summarize();
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// read one register and judge it
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host.rd(a, d);
		check(n, d, e);
	endtask
	// one cycle of causes, timer events and clear sources, then all low
	task automatic pulse(input logic [3:0] pc, input logic [2:0] pt, input logic [3:0] ps);
		@(posedge clk);
		c <= pc;
		t <= pt;
		s <= ps;
		@(posedge clk);
		c <= 4'h0;
		t <= 3'h0;
		s <= 4'h0;
	endtask
	task automatic t_reset();
		rchk("boost", 8'h06, 8'h00);
		rchk("charger", 8'h05, 8'h00);
		i_host.wr(8'h06, 8'hFF);
		rchk("boost ro", 8'h06, 8'h00);
		rchk("unmapped", 8'h3C, 8'h00);
		rchk("control", 8'h08, 8'h00);
	endtask
	task automatic t_sense();
		@(posedge clk);
		l <= 6'h3F;
		i_host.wr(8'h07, 8'h00);
		rchk("sense all", 8'h07, 8'hBE);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			l <= 6'h01 << i;
			rchk("sense", 8'h07, (i == 5) ? 8'h80 : 8'h02 << i);
		end
	endtask
	task automatic t_boost();
		for (int i = 0; i < 4; i++) begin
			pulse(4'h1 << i, 3'h0, 4'h0);
			rchk("boost set", 8'h06, 8'h01 << i);
			rchk("boost clr", 8'h06, 8'h00);
		end
		@(posedge clk);
		c <= 4'hE;
		rchk("boost hold", 8'h06, 8'h0E);
		rchk("boost hold", 8'h06, 8'h0E);
		rchk("raw causes", 8'h09, 8'h0E);
		@(posedge clk);
		c <= 4'h0;
		rchk("boost last", 8'h06, 8'h0E);
		rchk("boost gone", 8'h06, 8'h00);
	endtask
	// off, start-up and charge entry in turn; start-up spares the low flags
	task automatic t_clear();
		logic [7:0] exp [3] = '{8'h00, 8'h07, 8'h00};
		for (int j = 0; j < 3; j++) begin
			pulse(4'hF, 3'h0, 4'h0);
			pulse(4'h0, 3'h0, 4'h8 >> j);
			rchk("boost cleared", 8'h06, exp[j]);
		end
		pulse(4'hF, 3'h0, 4'h0);
		i_host.wr(8'h08, 8'h01);
		rchk("soft reset", 8'h06, 8'h00);
	endtask
	task automatic t_chg();
		for (int i = 0; i < 3; i++) begin
			pulse(4'h0, 3'h1 << i, 4'h0);
			rchk("charger set", 8'h05, (8'h02 << i) | 8'h01);
			rchk("charger clr", 8'h05, 8'h00);
		end
		pulse(4'h0, 3'h7, 4'h0);
		pulse(4'h0, 3'h0, 4'h1);
		rchk("host mode", 8'h05, 8'h00);
		pulse(4'h0, 3'h7, 4'h0);
		i_host.wr(8'h08, 8'h02);
		// the pulse stands in the cycle after the write edge
		#1;
		check("trim pulse", {7'h00, trim}, 8'h01);
		rchk("trim reset", 8'h05, 8'h00);
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		c = 4'h0;
		t = 3'h0;
		l = 6'h00;
		s = 4'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_sense();
		t_boost();
		t_clear();
		t_chg();
		summarize();
	end
	// watchdog: the sequence needs about a hundred and thirty cycles
	initial begin
		#20000;
		err_count++;
		summarize();
	end
endmodule
`default_nettype wire
